// ==== verilog/tbr_regs.svh ====
// Constants of the program memory table-read block.
// Assumes inclusion by bare name from design and bench files.
`ifndef TBR_REGS_SVH
`define TBR_REGS_SVH

`define TBR_PTR_W 22
`define TBR_WADDR_W 13
`define TBR_WORDS 8192
`define TBR_DATA_W 16
`define TBR_PTR_RST 22'h000000
`define TBR_LATCH_RST 8'h00
`define TBR_BYTE_SEL_BIT 0
`define TBR_READ_CYCLES 2

`endif

// ==== verilog/tbr_pkg.sv ====
// Types of the program memory table-read block.
// Assumes the constants header is compiled alongside.
package tbr_pkg;

    typedef enum logic [1:0] {
        TBR_OP_PLAIN,
        TBR_OP_POSTINC,
        TBR_OP_OTHER0,
        TBR_OP_OTHER1
    } tbr_op_t;

    typedef enum logic [1:0] {
        TBR_IDLE,
        TBR_FETCH,
        TBR_DONE
    } tbr_state_t;

endpackage : tbr_pkg

// ==== verilog/tbr_flash.sv ====
// Word-organised program memory with registered read data.
// Assumes contents preloaded by the write port; one-cycle read latency.
`timescale 1ns/100ps
`include "tbr_regs.svh"

module tbr_flash (
    input wire logic i_clk,
    input wire logic i_wr_en,
    input wire logic [`TBR_WADDR_W-1:0] i_wr_addr,
    input wire logic [`TBR_DATA_W-1:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic [`TBR_WADDR_W-1:0] i_rd_addr,
    output logic [`TBR_DATA_W-1:0] o_rd_data
);

    logic [`TBR_DATA_W-1:0] mem [0:`TBR_WORDS-1];

    // No reset on the array; contents come from the loader
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        if (i_rd_en) begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule : tbr_flash

// ==== verilog/tbr_top.sv ====
// Table-read path: byte fetch from word program memory into a latch.
// Assumes the core issues one request pulse and honours the stall.
`timescale 1ns/100ps
`include "tbr_regs.svh"

module tbr_top (
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    input wire logic i_read_req,
    input wire logic [1:0] i_read_op,
    input wire logic i_ptr_upper_we,
    input wire logic i_ptr_high_we,
    input wire logic i_ptr_low_we,
    input wire logic [7:0] i_ptr_wdata,
    input wire logic i_load_we,
    input wire logic [`TBR_WADDR_W-1:0] i_load_addr,
    input wire logic [`TBR_DATA_W-1:0] i_load_data,
    output logic O_STALL,
    output logic O_DONE,
    output logic O_BAD_OP,
    output logic [7:0] O_TABLE_LATCH,
    output logic [`TBR_PTR_W-1:0] O_TABLE_POINTER
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte address to word address: drop the half selector
    function automatic logic [`TBR_WADDR_W-1:0] word_of(
        input logic [`TBR_PTR_W-1:0] p);
        word_of = p[`TBR_WADDR_W:1];
    endfunction : word_of

    function automatic logic [7:0] half_of(
        input logic [`TBR_DATA_W-1:0] w, input logic sel);
        half_of = sel ? w[15:8] : w[7:0];
    endfunction : half_of

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    tbr_pkg::tbr_state_t state_q;
    tbr_pkg::tbr_op_t op_q;
    logic [`TBR_PTR_W-1:0] ptr_q;
    logic [`TBR_PTR_W-1:0] addr_q;
    logic [7:0] latch_q;
    logic done_q;
    logic bad_q;
    logic [`TBR_DATA_W-1:0] rd_word;
    logic good_op;
    logic start;

    assign good_op = (i_read_op == 2'(tbr_pkg::TBR_OP_PLAIN)) ||
                     (i_read_op == 2'(tbr_pkg::TBR_OP_POSTINC));
    assign start = i_read_req && (state_q == tbr_pkg::TBR_IDLE) && good_op;

    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= tbr_pkg::TBR_IDLE;
            op_q <= tbr_pkg::TBR_OP_PLAIN;
            addr_q <= `TBR_PTR_RST;
        end else begin
            case (state_q)
                tbr_pkg::TBR_IDLE: begin
                    if (start) begin
                        // Address frozen so pointer writes cannot race
                        addr_q <= ptr_q;
                        op_q <= tbr_pkg::tbr_op_t'(i_read_op);
                        state_q <= tbr_pkg::TBR_FETCH;
                    end
                end
                tbr_pkg::TBR_FETCH: begin
                    state_q <= tbr_pkg::TBR_DONE;
                end
                tbr_pkg::TBR_DONE: begin
                    state_q <= tbr_pkg::TBR_IDLE;
                end
                default: begin
                    state_q <= tbr_pkg::TBR_IDLE;
                end
            endcase
        end
    end

    // Stall the core for the whole access, drop on completion
    assign O_STALL = start || (state_q == tbr_pkg::TBR_FETCH);

    // ------------------------------------------------------------
    // Memory
    // ------------------------------------------------------------
    tbr_flash u_flash (
        .i_clk(I_MCLK),
        .i_wr_en(i_load_we),
        .i_wr_addr(i_load_addr),
        .i_wr_data(i_load_data),
        .i_rd_en(state_q == tbr_pkg::TBR_IDLE),
        .i_rd_addr(word_of(start ? ptr_q : addr_q)),
        .o_rd_data(rd_word)
    );

    // ------------------------------------------------------------
    // Latch
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            latch_q <= `TBR_LATCH_RST;
        end else if (state_q == tbr_pkg::TBR_FETCH) begin
            // Single byte per operation; wider values need more reads
            latch_q <= half_of(rd_word, addr_q[`TBR_BYTE_SEL_BIT]);
        end
    end

    // ------------------------------------------------------------
    // Pointer
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ptr_q <= `TBR_PTR_RST;
        end else if (state_q == tbr_pkg::TBR_FETCH &&
                     op_q == tbr_pkg::TBR_OP_POSTINC) begin
            // Step after capture; captured address already frozen
            ptr_q <= addr_q + `TBR_PTR_W'(1);
        end else if (state_q == tbr_pkg::TBR_IDLE && !start) begin
            // Base address load by software before reads
            if (i_ptr_upper_we) begin
                ptr_q[21:16] <= i_ptr_wdata[5:0];
            end
            if (i_ptr_high_we) begin
                ptr_q[15:8] <= i_ptr_wdata;
            end
            if (i_ptr_low_we) begin
                ptr_q[7:0] <= i_ptr_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            done_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            done_q <= (state_q == tbr_pkg::TBR_FETCH);
            bad_q <= i_read_req && (state_q == tbr_pkg::TBR_IDLE) &&
                     !good_op;
        end
    end

    assign O_DONE = done_q;
    assign O_BAD_OP = bad_q;
    assign O_TABLE_LATCH = latch_q;
    assign O_TABLE_POINTER = ptr_q;

endmodule : tbr_top

// ==== bench/tbr_ldr.sv ====
// Flash programmer stand-in: fills words at start.
// Assumes a running clock; contents set before reads.
`timescale 1ns/100ps
`include "tbr_regs.svh"
module tbr_ldr (
    input wire logic i_clk,
    output logic o_we,
    output logic [`TBR_WADDR_W-1:0] o_addr,
    output logic [`TBR_DATA_W-1:0] o_data,
    output logic o_done
);
    initial begin
        o_we = 1'b0;
        o_addr = '0;
        o_data = '0;
        o_done = 1'b0;
        for (int i = 0; i < 17; i++) begin
            logic [7:0] b;
            b = (i < 16) ? 8'(i) : 8'hff;
            @(posedge i_clk);
            o_we <= 1'b1;
            o_addr <= {5'h1f, b};
            o_data <= {b ^ 8'h5a, b ^ 8'hc3};
        end
        @(posedge i_clk);
        o_we <= 1'b0;
        o_done <= 1'b1;
    end
endmodule : tbr_ldr

// ==== bench/tbr_top_sva.sv ====
// Checker on the table-read ports.
// Assumes binding to tbr_top; sees only its ports.
`timescale 1ns/100ps
`include "tbr_regs.svh"
module tbr_top_sva (
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    input wire logic i_read_req,
    input wire logic [1:0] i_read_op,
    input wire logic O_STALL,
    input wire logic O_DONE,
    input wire logic O_BAD_OP,
    input wire logic [7:0] O_TABLE_LATCH,
    input wire logic [`TBR_PTR_W-1:0] O_TABLE_POINTER
);
    logic st_q;
    logic tk;
    logic bd;
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) st_q <= 1'b0;
        else st_q <= O_STALL;
    end
    // Idle: no stall last cycle, no answer now
    assign tk = i_read_req && !i_read_op[1] && !O_DONE && !st_q;
    assign bd = i_read_req && i_read_op[1] && !O_DONE && !st_q;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    a_done_two_cyc: assert property (tk |-> ##2 O_DONE)
        else $error("done late");
    a_stall_span: assert property (tk |-> O_STALL ##1 O_STALL ##1 !O_STALL)
        else $error("stall span");
    a_done_pulse: assert property (O_DONE |=> !O_DONE)
        else $error("done long");
    a_inc_one: assert property (tk && i_read_op[0] |-> ##2
        O_TABLE_POINTER == $past(O_TABLE_POINTER, 2) + 1'b1)
        else $error("no step");
    a_plain_keep: assert property (tk && !i_read_op[0] |-> ##2
        O_TABLE_POINTER == $past(O_TABLE_POINTER, 2))
        else $error("ptr moved");
    a_latch_when: assert property ($changed(O_TABLE_LATCH) |-> O_DONE)
        else $error("latch moved");
    a_bad_flag: assert property (bd |=> O_BAD_OP)
        else $error("no bad flag");
    a_bad_noread: assert property (O_BAD_OP |-> !O_DONE ##1 !O_DONE)
        else $error("bad op read");
    c_inc: cover property (tk && i_read_op[0]);
    c_plain: cover property (tk && !i_read_op[0]);
    c_bad: cover property (O_BAD_OP);
endmodule : tbr_top_sva
bind tbr_top tbr_top_sva sva (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN),
    .i_read_req(i_read_req), .i_read_op(i_read_op), .O_STALL(O_STALL),
    .O_DONE(O_DONE), .O_BAD_OP(O_BAD_OP), .O_TABLE_LATCH(O_TABLE_LATCH),
    .O_TABLE_POINTER(O_TABLE_POINTER));

// ==== bench/tbr_top_tb.sv ====
// Testbench of the table-read block.
// Assumes the loader fills words 1f00-1f0f and 1fff first.
`timescale 1ns/100ps
`include "tbr_regs.svh"
module tbr_top_tb;
    logic clk = 1'b0, rstn = 1'b0, req = 1'b0;
    logic [1:0] op = 2'h0;
    logic [2:0] pwe = 3'h0;
    logic [7:0] pwd = 8'h00, lat;
    logic lwe, ldone, stall, done, bad;
    logic [`TBR_WADDR_W-1:0] la;
    logic [`TBR_DATA_W-1:0] ld;
    logic [`TBR_PTR_W-1:0] ptr;
    int failures = 0, num_checks = 0;
    always #2 clk = ~clk;
    tbr_ldr ldr (.i_clk(clk), .o_we(lwe), .o_addr(la), .o_data(ld),
        .o_done(ldone));
    tbr_top dut (.I_MCLK(clk), .I_RSTN(rstn), .i_read_req(req),
        .i_read_op(op), .i_ptr_upper_we(pwe[2]), .i_ptr_high_we(pwe[1]),
        .i_ptr_low_we(pwe[0]), .i_ptr_wdata(pwd), .i_load_we(lwe),
        .i_load_addr(la), .i_load_data(ld), .O_STALL(stall), .O_DONE(done),
        .O_BAD_OP(bad), .O_TABLE_LATCH(lat), .O_TABLE_POINTER(ptr));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        if (failures == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic wptr(input logic [21:0] p);
        for (int i = 2; i >= 0; i--) begin
            @(posedge clk);
            pwe <= 3'h1 << i;
            pwd <= 8'(p >> (8 * i));
        end
        @(posedge clk);
        pwe <= 3'h0;
    endtask : wptr
    task automatic rd(input logic [1:0] o, input logic [7:0] el,
        input logic [21:0] ep);
        @(posedge clk);
        req <= 1'b1;
        op <= o;
        @(posedge clk);
        req <= 1'b0;
        #1 chk(24'(stall), 24'h1);
        for (int n = 0; n < 4 && done !== 1'b1; n++) @(posedge clk) #1;
        if (done !== 1'b1) begin
            failures++;
            conclude();
        end
        chk(24'(stall), 24'h0);
        chk(24'(lat), 24'(el));
        chk(24'(ptr), 24'(ep));
    endtask : rd
    task automatic bad_op(input logic [1:0] o, input logic [7:0] el);
        @(posedge clk);
        req <= 1'b1;
        op <= o;
        @(posedge clk);
        req <= 1'b0;
        #1 chk(24'(bad), 24'h1);
        @(posedge clk) #1 chk(24'({done, lat}), 24'(el));
    endtask : bad_op
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int n = 0; n < 40 && ldone !== 1'b1; n++) @(posedge clk);
        if (ldone !== 1'b1) begin
            failures++;
            conclude();
        end
        // Step order: low then high half of one word
        wptr(22'h003e04);
        rd(2'h1, 8'hc1, 22'h003e05);
        rd(2'h1, 8'h58, 22'h003e06);
        rd(2'h0, 8'hc0, 22'h003e06);
        // Top byte; upper bits do not reach memory, step wraps
        wptr(22'h3fffff);
        rd(2'h0, 8'ha5, 22'h3fffff);
        rd(2'h1, 8'ha5, 22'h000000);
        bad_op(2'h2, 8'ha5);
        bad_op(2'h3, 8'ha5);
        conclude();
    end
endmodule : tbr_top_tb
